// ### rtl/sram_ctrl_pkg.sv
package sram_ctrl_pkg;
    localparam int ADDR_W = 18;
    localparam int LANES = 8;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;
    localparam int DEPTH = 1 << ADDR_W;
    localparam int FIFO_DEPTH = 32;
    localparam logic [1:0] BURST_STEP = 2'h1;
    localparam logic [1:0] SAMPLE_LAST = 2'h2;
    localparam logic [1:0] SAMPLE_PREV = 2'h1;

    typedef enum logic [2:0] {
        OP_IDLE = 3'b000,
        OP_BANK_DESEL = 3'b001,
        OP_CHIP_DESEL = 3'b010,
        OP_READ = 3'b011,
        OP_WRITE = 3'b100
    } op_t;

    typedef struct packed {
        logic chipSelectN;
        logic bankSelA;
        logic bankSelB;
        logic loadOrStep;
        logic writeN;
        logic [LANES-1:0] laneMaskN;
        logic [ADDR_W-1:0] addr;
    } cmd_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] laneMaskN;
    } wr_slot_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } rd_word_t;
endpackage

// ### rtl/sync_fifo.sv
`timescale 1ns/1ps
// flop-based fifo; ready low when full so the writer stalls
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
    logic [PW:0] count, next_count;
    logic push, pop;

    always_comb begin
        inReady = (count != (PW+1)'(DEPTH));
        outValid = (count != '0);
        outData = mem[rdPtr];
        push = inValid && inReady;
        pop = outValid && outReady;
        next_wrPtr = push ? PW'(wrPtr + 1'b1) : wrPtr;
        next_rdPtr = pop ? PW'(rdPtr + 1'b1) : rdPtr;
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end
endmodule

// ### rtl/late_write_sram_bus_control.sv
`timescale 1ns/1ps
// How it works
// RULE1 - echo clocks track the link clock while echo drivers are on
// RULE2 - bank miss switches echo drivers off, pipelined
// RULE3 - chip-select deselect keeps echo clocks running
// RULE4 - bank selects match their polarity pins
// RULE5 - four banks use codes 00 to 11
// RULE6 - bank miss with load floats data, echo
// RULE7 - deselects and writes float data next cycle
// RULE8 - write loads address, data two cycles later
// RULE9 - all-masked write loads address, stores nothing
// RULE10 - read loads address, data next cycle
// RULE11 - step after read increments, reads next word
// RULE12 - step after write increments, stores later data
// RULE13 - all-masked step increments, stores nothing
// RULE14 - four words per address, then wrap
// RULE15 - controller may pause at bank switch
// RULE16 - inputs sampled on rising link clock edges
// RULE17 - burst counter steps low bits modulo four
// RULE18 - data pins float until first command
module late_write_sram_bus_control #(
    parameter int ADDR_W = sram_ctrl_pkg::ADDR_W,
    parameter int DATA_W = sram_ctrl_pkg::DATA_W,
    parameter int LANES = sram_ctrl_pkg::LANES,
    parameter int FIFO_DEPTH = sram_ctrl_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic linkClk,
    input wire logic chip_select_n,
    input wire logic bank_sel_a,
    input wire logic bank_sel_b,
    input wire logic polarity_pin_a,
    input wire logic polarity_pin_b,
    input wire logic load_or_step,
    input wire logic writeN,
    input wire logic [LANES-1:0] lane_mask_n,
    input wire logic [ADDR_W-1:0] addrIn,
    input wire logic [DATA_W-1:0] dqIn,
    output logic [DATA_W-1:0] dqOut,
    output logic dqOe,
    output logic echo_out_a,
    output logic echo_out_a_n,
    output logic echo_out_b,
    output logic echo_out_b_n,
    output logic echoOe,
    output logic readValid,
    input wire logic readReady,
    output logic [sram_ctrl_pkg::ADDR_W+sram_ctrl_pkg::DATA_W-1:0] readWord
);
    localparam int LANE_W = DATA_W / LANES;

    ////////////////////////////////////////////////////////////////////////
    // link clock: three flops, edge counts once stages two and three agree
    logic [2:0] clkSync, next_clkSync;
    logic linkLevel, next_linkLevel;
    logic linkRise;
    always_comb begin
        next_clkSync = {clkSync[1:0], linkClk};
        next_linkLevel = linkLevel;
        if (clkSync[2] == clkSync[1]) begin
            next_linkLevel = clkSync[2];
        end
        linkRise = (clkSync[2] == clkSync[1]) && clkSync[2] && !linkLevel; // see RULE16
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clkSync <= '0;
            linkLevel <= 1'b0;
        end else begin
            clkSync <= next_clkSync;
            linkLevel <= next_linkLevel;
        end
    end

    // the pins are stable around the link edge, so a three-stage pipe of the
    // bus sampled alongside the link clock lines up with linkRise
    sram_ctrl_pkg::cmd_t pinNow;
    sram_ctrl_pkg::cmd_t pinPipe [3];
    logic [DATA_W-1:0] dqPipe [3];
    always_comb begin
        pinNow = '{chipSelectN: chip_select_n, bankSelA: bank_sel_a, bankSelB: bank_sel_b,
                   loadOrStep: load_or_step, writeN: writeN, laneMaskN: lane_mask_n, addr: addrIn};
    end
    always_ff @(posedge clk) begin
        pinPipe[0] <= pinNow;
        pinPipe[1] <= pinPipe[0];
        pinPipe[2] <= pinPipe[1];
        dqPipe[0] <= dqIn;
        dqPipe[1] <= dqPipe[0];
        dqPipe[2] <= dqPipe[1];
    end
    sram_ctrl_pkg::cmd_t cmd;
    logic [DATA_W-1:0] dqSample;
    always_comb begin
        cmd = pinPipe[sram_ctrl_pkg::SAMPLE_LAST];
        dqSample = dqPipe[sram_ctrl_pkg::SAMPLE_LAST];
    end

    ////////////////////////////////////////////////////////////////////////
    // command decode
    logic bankMatch, anyLane;
    sram_ctrl_pkg::op_t op, next_op;
    always_comb begin
        bankMatch = (cmd.bankSelA == polarity_pin_a) && (cmd.bankSelB == polarity_pin_b); // see RULE4 RULE5
        anyLane = ~&cmd.laneMaskN;
        next_op = op;
        if (!cmd.loadOrStep) begin
            if (!bankMatch) begin
                next_op = sram_ctrl_pkg::OP_BANK_DESEL; // see RULE6
            end else if (cmd.chipSelectN) begin
                next_op = sram_ctrl_pkg::OP_CHIP_DESEL; // see RULE3
            end else if (cmd.writeN) begin
                next_op = sram_ctrl_pkg::OP_READ; // see RULE10
            end else begin
                next_op = sram_ctrl_pkg::OP_WRITE; // see RULE8
            end
        end
        // load_or_step high keeps the previous operation, chip and bank ignored (see RULE11)
    end

    ////////////////////////////////////////////////////////////////////////
    // address: base plus linear burst offset
    logic [ADDR_W-1:0] baseAddr, next_baseAddr;
    logic [1:0] burstOff, next_burstOff;
    logic [ADDR_W-1:0] curAddr;
    always_comb begin
        next_baseAddr = baseAddr;
        next_burstOff = burstOff;
        if (!cmd.loadOrStep) begin
            next_baseAddr = cmd.addr;
            next_burstOff = '0;
        end else if (op == sram_ctrl_pkg::OP_READ || op == sram_ctrl_pkg::OP_WRITE) begin
            next_burstOff = burstOff + sram_ctrl_pkg::BURST_STEP; // see RULE14 RULE17
        end
        curAddr = {next_baseAddr[ADDR_W-1:2], 2'(next_baseAddr[1:0] + next_burstOff)}; // see RULE17
    end

    ////////////////////////////////////////////////////////////////////////
    // array and pipelines, all stepped by linkRise
    logic [DATA_W-1:0] mem [1 << ADDR_W];
    sram_ctrl_pkg::wr_slot_t wrSlot [2];
    logic [1:0] wrLive;
    logic [DATA_W-1:0] rdData;
    logic rdPend, echoPend, started;
    logic isWrite, isRead, fifoReady;

    always_comb begin
        isWrite = (next_op == sram_ctrl_pkg::OP_WRITE);
        isRead = (next_op == sram_ctrl_pkg::OP_READ);
    end

    // write data arrives two link edges after its command (see RULE8 RULE12)
    always_ff @(posedge clk) begin
        if (linkRise) begin
            wrSlot[0] <= '{addr: curAddr, laneMaskN: cmd.laneMaskN};
            wrSlot[1] <= wrSlot[0];
            if (wrLive[1]) begin
                for (int i = 0; i < LANES; i++) begin
                    if (!wrSlot[1].laneMaskN[i]) begin
                        mem[wrSlot[1].addr][i*LANE_W +: LANE_W] <= dqSample[i*LANE_W +: LANE_W]; // see RULE9 RULE13
                    end
                end
            end
            if (isRead) begin
                // late-write coherence not modelled: reads see the array as stored
                rdData <= mem[curAddr]; // see RULE10 RULE11
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            op <= sram_ctrl_pkg::OP_IDLE;
            baseAddr <= '0;
            burstOff <= '0;
            wrLive <= '0;
            rdPend <= 1'b0;
            echoPend <= 1'b0;
            started <= 1'b0;
        end else if (linkRise) begin
            op <= next_op;
            baseAddr <= next_baseAddr;
            burstOff <= next_burstOff;
            wrLive <= {wrLive[0], isWrite && anyLane};
            rdPend <= isRead;
            echoPend <= (next_op != sram_ctrl_pkg::OP_BANK_DESEL) && (next_op != sram_ctrl_pkg::OP_IDLE);
            started <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output stage: one link cycle after the command
    logic echoLevel;
    always_comb begin
        echoLevel = linkLevel; // see RULE1
        dqOe = started && rdPend; // see RULE7 RULE18
        echoOe = started && echoPend; // see RULE2 RULE3 RULE6
        echo_out_a = echoOe & echoLevel;
        echo_out_b = echoOe & echoLevel;
        echo_out_a_n = echoOe & ~echoLevel;
        echo_out_b_n = echoOe & ~echoLevel;
        dqOut = rdData;
    end

    // each read word goes out on a stream while the fifo has room; a full fifo drops nothing
    // from the pins, but a read arriving while the held copy still waits for room is not copied
    logic rdCopy, next_rdCopy;
    sram_ctrl_pkg::rd_word_t copyWord, next_copyWord;
    always_comb begin
        next_rdCopy = rdCopy && !fifoReady;
        next_copyWord = copyWord;
        if (linkRise && isRead && (!rdCopy || fifoReady)) begin
            next_rdCopy = 1'b1;
            next_copyWord = '{addr: curAddr, data: mem[curAddr]};
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdCopy <= 1'b0;
            copyWord <= '0;
        end else begin
            rdCopy <= next_rdCopy;
            copyWord <= next_copyWord;
        end
    end

    sync_fifo #(
        .WIDTH(ADDR_W + DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) readFifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .inValid(rdCopy),
        .inReady(fifoReady),
        .inData(copyWord),
        .outValid(readValid),
        .outReady(readReady),
        .outData(readWord)
    );
endmodule

// ### bench/sram_ctrl_asserts.sv
`timescale 1ns/1ps
module sram_ctrl_asserts (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic linkClk,
    input wire logic chip_select_n,
    input wire logic bank_sel_a,
    input wire logic bank_sel_b,
    input wire logic polarity_pin_a,
    input wire logic polarity_pin_b,
    input wire logic load_or_step,
    input wire logic writeN,
    input wire logic dqOe,
    input wire logic echo_out_a,
    input wire logic echo_out_a_n,
    input wire logic echo_out_b,
    input wire logic echoOe,
    input wire logic readValid
);
    wire logic hit = bank_sel_a == polarity_pin_a && bank_sel_b == polarity_pin_b;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // a command counts at the first clk that sees the link clock high
    sequence s_take;
        $rose(linkClk);
    endsequence
    sequence s_load;
        s_take ##0 !load_or_step;
    endsequence
    AST_OE_PHASE: assert property ($changed(dqOe) || $changed(echoOe) |-> linkClk)
        else $error("enable moved in link low phase");
    AST_ECHO_OFF: assert property (!echoOe |-> !echo_out_a && !echo_out_a_n && !echo_out_b)
        else $error("echo driven while off");
    AST_ECHO_TRACK: assert property ($rose(echo_out_a) |-> linkClk)
        else $error("echo rose in link low phase");
    AST_BANK_MISS: assert property (s_load ##0 !hit |-> ##8 !echoOe && !dqOe)
        else $error("bank miss left drivers on");
    AST_DESEL_HOLD: assert property (s_take ##0 load_or_step && !echoOe |-> ##8 !echoOe && !dqOe)
        else $error("continue left deselect");
    AST_CHIP_DESEL: assert property (s_load ##0 hit && chip_select_n && echoOe |-> ##8 echoOe && !dqOe)
        else $error("chip deselect wrong");
    AST_WRITE_FLOAT: assert property (s_load ##0 hit && !chip_select_n && !writeN |-> ##8 echoOe && !dqOe)
        else $error("write left data driven");
    AST_READ: assert property (s_load ##0 hit && !chip_select_n && writeN |-> ##8 dqOe && echoOe)
        else $error("read not driven");
    AST_READ_STEP: assert property (s_take ##0 load_or_step && dqOe |-> ##8 dqOe)
        else $error("read continue not driven");
    AST_RESET_IDLE: assert property ($fell(sys_rst) |-> !dqOe && !echoOe && !readValid)
        else $error("outputs active after reset");
endmodule
bind late_write_sram_bus_control sram_ctrl_asserts sram_ctrl_asserts_inst (.*);

// ### bench/host_model.sv
`timescale 1ns/1ps
module host_model (
    input wire sram_ctrl_pkg::cmd_t cmdIn,
    input wire logic [71:0] dIn,
    output logic linkClk,
    output sram_ctrl_pkg::cmd_t pins,
    output logic [71:0] dqIn
);
    // offset keeps link edges clear of system clock edges
    initial begin
        linkClk = 1'b0;
        pins = '1;
        dqIn = 72'h0;
        #3;
        forever #80 linkClk = ~linkClk;
    end
    always @(posedge linkClk) begin
        pins <= cmdIn;
        // zero means released: toggle rather than hold stale data
        dqIn <= (dIn != 72'h0) ? dIn : ~dqIn;
    end
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    typedef struct {logic [3:0] k; logic [7:0] m; logic [17:0] a; logic [71:0] d; logic [1:0] e;} row_t;
    // k = {bank miss, chip select, load/step, write}; e = {data on, echo on}
    row_t rows [18] = '{'{4'h0,8'h0,18'h6,72'h0,2'h1}, '{4'h2,8'h0,18'h0,72'h0,2'h1},
        '{4'h2,8'h0,18'h0,72'h11,2'h1}, '{4'h2,8'h0,18'h0,72'h2222_2222,2'h1},
        '{4'h0,8'hFF,18'h4,72'h33,2'h1}, '{4'h2,8'hFF,18'h0,72'h44,2'h1},
        '{4'h0,8'hFE,18'h7,72'hBAD0,2'h1}, '{4'h5,8'h0,18'h0,72'hBAD1,2'h1},
        '{4'h6,8'h0,18'h0,72'h4444_4444,2'h1}, '{4'h1,8'h0,18'h6,72'h11,2'h3},
        '{4'h2,8'h0,18'h0,72'h2222_2244,2'h3}, '{4'h2,8'h0,18'h0,72'h33,2'h3},
        '{4'h2,8'h0,18'h0,72'h44,2'h3}, '{4'h2,8'h0,18'h0,72'h11,2'h3},
        '{4'h9,8'h0,18'h0,72'h0,2'h0}, '{4'h2,8'h0,18'h0,72'h0,2'h0},
        '{4'h1,8'h0,18'h5,72'h44,2'h3}, '{4'h2,8'h0,18'h0,72'h11,2'h3}};
    logic [71:0] mem [4] = '{72'h33, 72'h44, 72'h11, 72'h2222_2244};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic readReady = 1'b0;
    logic lSeen = 1'b0;
    logic [1:0] pol = 2'h0;
    logic [1:0] bank = 2'h0;
    logic [71:0] dIn = 72'h0;
    logic [71:0] dqOut;
    logic [71:0] dqIn;
    logic [89:0] readWord;
    logic linkClk, dqOe, echoOe, readValid;
    sram_ctrl_pkg::cmd_t cmd = '1;
    sram_ctrl_pkg::cmd_t pins;
    int mismatches = 0;
    int nTests = 0;
    always #5 clk = ~clk;
    always @(posedge clk) lSeen <= linkClk;
    host_model host_model_inst (.cmdIn(cmd), .dIn(dIn), .linkClk(linkClk), .pins(pins), .dqIn(dqIn));
    late_write_sram_bus_control late_write_sram_bus_control_inst (
        .clk(clk), .sys_rst(sys_rst), .linkClk(linkClk),
        .chip_select_n(pins.chipSelectN), .bank_sel_a(pins.bankSelA), .bank_sel_b(pins.bankSelB),
        .polarity_pin_a(pol[1]), .polarity_pin_b(pol[0]), .load_or_step(pins.loadOrStep),
        .writeN(pins.writeN), .lane_mask_n(pins.laneMaskN), .addrIn(pins.addr), .dqIn(dqIn),
        .dqOut(dqOut), .dqOe(dqOe), .echo_out_a(), .echo_out_a_n(), .echo_out_b(), .echo_out_b_n(),
        .echoOe(echoOe), .readValid(readValid), .readReady(readReady), .readWord(readWord));
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (mismatches == 0 && nTests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [89:0] got, input logic [89:0] exp);
        nTests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one command per link period; d is write data, or expected read data when e[1]
    task automatic step(input logic [3:0] k, input logic [7:0] m, input logic [17:0] a,
        input logic [71:0] d, input logic [1:0] e);
        int n;
        @(posedge clk);
        cmd <= '{k[2], bank[1] ^ k[3], bank[0], k[1], k[0], m, a};
        dIn <= e[1] ? 72'h0 : d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!(linkClk === 1'b1 && lSeen === 1'b0) && n < 40);
        if (n >= 40) begin
            mismatches++;
            give_verdict();
        end
        repeat (9) @(posedge clk);
        chk(90'(dqOe), 90'(e[1]));
        chk(90'(echoOe), 90'(e[0]));
        if (e[1]) chk(90'(dqOut), 90'(d));
    endtask
    initial begin
        int cnt;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clk);
        chk(90'(dqOe), 90'h0);
        foreach (rows[i]) step(rows[i].k, rows[i].m, rows[i].a, rows[i].d, rows[i].e);
        for (int p = 0; p < 4; p++) begin
            pol <= 2'(p);
            bank <= 2'(p);
            step(4'h1, 8'h0, 18'h5, 72'h44, 2'h3);
            bank <= 2'(p) ^ 2'h1;
            step(4'h1, 8'h0, 18'h5, 72'h0, 2'h0);
            bank <= 2'(p);
            step(4'h9, 8'h0, 18'h5, 72'h0, 2'h0);
        end
        for (int i = 0; i < 21; i++) step(i == 0 ? 4'h1 : 4'h2, 8'h0, 18'h5, mem[(i + 1) % 4], 2'h3);
        step(4'h5, 8'h0, 18'h0, 72'h0, 2'h1);
        chk(90'(readValid), 90'h1);
        chk(readWord, {18'h6, 72'h11});
        readReady <= 1'b1;
        cnt = 0;
        repeat (48) begin
            @(posedge clk);
            if (readValid === 1'b1) cnt++;
        end
        chk(90'(cnt), 90'(sram_ctrl_pkg::FIFO_DEPTH));
        give_verdict();
    end
endmodule
